// ==== core/acm_defs.vh ====
// Constants shared by the access control entry frame matcher.
// Assumes it is included by bare name from the core modules.
// Function
// - Source address qualifier only for Ethernet-type/ARP entries
// - Source address any or exact 48-bit match
// - Destination qualifier: any, group, all-stations, single-station
// - Destination specific needs exact 48-bit match
// - VLAN specific matches stored ID 0..4095
// - Priority compared to stored 0..7 unless any
// - Protocol any, specific, ICMP, UDP, TCP
// - Specific protocol equals stored 8-bit value
// - TTL zero, non-zero or any
// - Fragment test: more-fragments or nonzero offset
// - Options no, yes or any
// - Source IPv4 any, host or masked network
// - Destination IPv4 same as source qualifier
// - Hold 32-bit address and mask per qualifier
// - IPv4/ARP entries match only that frame kind
// - Deny match drops frame, permit passes
`ifndef ACM_DEFS_VH
`define ACM_DEFS_VH

// ==========================================
// Frame kinds
`define ACM_KIND_ANY 2'h0
`define ACM_KIND_ETYPE 2'h1
`define ACM_KIND_ARP 2'h2
`define ACM_KIND_IPV4 2'h3

// ==========================================
// Qualifier encodings
`define ACM_ANY 1'h0
`define ACM_SPECIFIC 1'h1
`define ACM_DA_ANY 3'h0
`define ACM_DA_GROUP 3'h1
`define ACM_DA_ALL 3'h2
`define ACM_DA_SINGLE 3'h3
`define ACM_DA_SPECIFIC 3'h4
`define ACM_PROTO_ANY 3'h0
`define ACM_PROTO_SPECIFIC 3'h1
`define ACM_PROTO_ICMP 3'h2
`define ACM_PROTO_UDP 3'h3
`define ACM_PROTO_TCP 3'h4
`define ACM_TRI_ANY 2'h0
`define ACM_TRI_NO 2'h1
`define ACM_TRI_YES 2'h2
`define ACM_IP_ANY 2'h0
`define ACM_IP_HOST 2'h1
`define ACM_IP_NETWORK 2'h2

// ==========================================
// Protocol numbers and action
`define ACM_IPPROTO_ICMP 8'h01
`define ACM_IPPROTO_UDP 8'h11
`define ACM_IPPROTO_TCP 8'h06
`define ACM_ACT_PERMIT 1'h0
`define ACM_ACT_DENY 1'h1

`endif

// ==== core/acm_ip_qual.v ====
// Address qualifier for one IPv4 address: any, host or masked network.
// Assumes inputs are stable on the clock of the instantiating module.
`timescale 1ns/1ps
`include "acm_defs.vh"

module acm_ip_qual (
  input wire [1:0] mode_in,
  input wire [31:0] stored_addr_in,
  input wire [31:0] stored_mask_in,
  input wire [31:0] frame_addr_in,
  output reg ok_out
);
  always @* begin
    case (mode_in)
      `ACM_IP_ANY: ok_out = 1'b1;
      `ACM_IP_HOST: ok_out = (frame_addr_in == stored_addr_in);
      `ACM_IP_NETWORK: ok_out =
        ((frame_addr_in & stored_mask_in) == (stored_addr_in & stored_mask_in));
      // Unused code never matches so a bad setting fails safe
      default: ok_out = 1'b0;
    endcase
  end
endmodule

// ==== core/acm_frame_matcher.v ====
// Matches one parsed frame header against one access control entry.
// Assumes header fields arrive with a one-cycle valid strobe from logic on
// clk_in and that entry settings are static while frames are checked.
`timescale 1ns/1ps
`include "acm_defs.vh"

module acm_frame_matcher (
  input wire clk_in,
  input wire nrst_in,
  // Entry settings
  input wire [1:0] entry_kind_in,
  input wire entry_action_in,
  input wire source_hw_address_mode_in,
  input wire [47:0] source_hw_address_in,
  input wire [2:0] destination_hw_address_mode_in,
  input wire [47:0] destination_hw_address_in,
  input wire vlan_mode_in,
  input wire [11:0] vlan_id_in,
  input wire prio_mode_in,
  input wire [2:0] prio_in,
  input wire [2:0] proto_mode_in,
  input wire [7:0] proto_in,
  input wire [1:0] ttl_mode_in,
  input wire [1:0] frag_mode_in,
  input wire [1:0] opt_mode_in,
  input wire [1:0] source_ipv4_mode_in,
  input wire [31:0] source_ipv4_address_in,
  input wire [31:0] source_ipv4_mask_in,
  input wire [1:0] destination_ipv4_mode_in,
  input wire [31:0] destination_ipv4_address_in,
  input wire [31:0] destination_ipv4_mask_in,
  // Frame header
  input wire hdr_valid_in,
  input wire [1:0] hdr_kind_in,
  input wire [47:0] hdr_src_hw_in,
  input wire [47:0] hdr_dst_hw_in,
  input wire hdr_tagged_in,
  input wire [11:0] hdr_vid_in,
  input wire [2:0] hdr_prio_in,
  input wire [7:0] hdr_proto_in,
  input wire [7:0] hdr_ttl_in,
  input wire hdr_more_fragments_flag_in,
  input wire [12:0] hdr_fragment_position_field_in,
  input wire hdr_options_in,
  input wire [31:0] hdr_src_ip_in,
  input wire [31:0] hdr_dst_ip_in,
  // Result
  output reg result_valid_out,
  output reg match_out,
  output reg drop_out,
  output reg pass_out,
  output reg [2:0] proto_class_out
);

  // ==========================================
  // Entry settings latched into registers
  // Holding the settings keeps the compare path short at 125 MHz.
  reg [1:0] kind_q;
  reg act_q;
  reg sa_mode_q;
  reg [47:0] sa_q;
  reg [2:0] da_mode_q;
  reg [47:0] da_q;
  reg vlan_mode_q;
  reg [11:0] vid_q;
  reg prio_mode_q;
  reg [2:0] prio_q;
  reg [2:0] proto_mode_q;
  reg [7:0] proto_q;
  reg [1:0] ttl_mode_q;
  reg [1:0] frag_mode_q;
  reg [1:0] opt_mode_q;
  reg [1:0] sip_mode_q;
  reg [31:0] sip_q;
  reg [31:0] sip_mask_q;
  reg [1:0] dip_mode_q;
  reg [31:0] dip_q;
  reg [31:0] dip_mask_q;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      kind_q <= `ACM_KIND_ANY;
      act_q <= `ACM_ACT_PERMIT;
      sa_mode_q <= `ACM_ANY;
      sa_q <= 48'h0;
      da_mode_q <= `ACM_DA_ANY;
      da_q <= 48'h0;
      vlan_mode_q <= `ACM_ANY;
      vid_q <= 12'h0;
      prio_mode_q <= `ACM_ANY;
      prio_q <= 3'h0;
      proto_mode_q <= `ACM_PROTO_ANY;
      proto_q <= 8'h0;
      ttl_mode_q <= `ACM_TRI_ANY;
      frag_mode_q <= `ACM_TRI_ANY;
      opt_mode_q <= `ACM_TRI_ANY;
      sip_mode_q <= `ACM_IP_ANY;
      sip_q <= 32'h0;
      sip_mask_q <= 32'h0;
      dip_mode_q <= `ACM_IP_ANY;
      dip_q <= 32'h0;
      dip_mask_q <= 32'h0;
    end else begin
      kind_q <= entry_kind_in;
      act_q <= entry_action_in;
      sa_mode_q <= source_hw_address_mode_in;
      sa_q <= source_hw_address_in;
      da_mode_q <= destination_hw_address_mode_in;
      da_q <= destination_hw_address_in;
      vlan_mode_q <= vlan_mode_in;
      vid_q <= vlan_id_in;
      prio_mode_q <= prio_mode_in;
      prio_q <= prio_in;
      proto_mode_q <= proto_mode_in;
      proto_q <= proto_in;
      ttl_mode_q <= ttl_mode_in;
      frag_mode_q <= frag_mode_in;
      opt_mode_q <= opt_mode_in;
      sip_mode_q <= source_ipv4_mode_in;
      sip_q <= source_ipv4_address_in;
      sip_mask_q <= source_ipv4_mask_in;
      dip_mode_q <= destination_ipv4_mode_in;
      dip_q <= destination_ipv4_address_in;
      dip_mask_q <= destination_ipv4_mask_in;
    end
  end

  // ==========================================
  // Layer-2 qualifiers
  reg kind_ok;
  reg sa_ok;
  reg da_ok;
  reg vlan_ok;
  reg prio_ok;
  wire da_group = hdr_dst_hw_in[40];
  wire da_all = &hdr_dst_hw_in;

  always @* begin
    // IPv4 and ARP frames never fall under an Ethernet-type entry
    case (kind_q)
      `ACM_KIND_ANY: kind_ok = 1'b1;
      `ACM_KIND_ETYPE: kind_ok = (hdr_kind_in == `ACM_KIND_ETYPE);
      `ACM_KIND_ARP: kind_ok = (hdr_kind_in == `ACM_KIND_ARP);
      `ACM_KIND_IPV4: kind_ok = (hdr_kind_in == `ACM_KIND_IPV4);
      default: kind_ok = 1'b0;
    endcase
  end

  always @* begin
    sa_ok = 1'b1;
    if ((kind_q == `ACM_KIND_ETYPE) || (kind_q == `ACM_KIND_ARP)) begin
      if (sa_mode_q == `ACM_SPECIFIC) begin
        sa_ok = (hdr_src_hw_in == sa_q);
      end
    end
  end

  always @* begin
    case (da_mode_q)
      `ACM_DA_ANY: da_ok = 1'b1;
      // Broadcast also carries the group bit, so group includes it
      `ACM_DA_GROUP: da_ok = da_group;
      `ACM_DA_ALL: da_ok = da_all;
      `ACM_DA_SINGLE: da_ok = !da_group;
      `ACM_DA_SPECIFIC: da_ok = (hdr_dst_hw_in == da_q);
      default: da_ok = 1'b0;
    endcase
  end

  always @* begin
    if (vlan_mode_q == `ACM_ANY) begin
      vlan_ok = 1'b1;
    end else begin
      vlan_ok = hdr_tagged_in && (hdr_vid_in == vid_q);
    end
    if (prio_mode_q == `ACM_ANY) begin
      prio_ok = 1'b1;
    end else begin
      prio_ok = hdr_tagged_in && (hdr_prio_in == prio_q);
    end
  end

  // ==========================================
  // IPv4 qualifiers, only meaningful for IPv4 entries
  reg proto_ok;
  reg ttl_ok;
  reg frag_ok;
  reg opt_ok;
  wire is_frag = hdr_more_fragments_flag_in || (hdr_fragment_position_field_in != 13'h0);
  wire ttl_nz = (hdr_ttl_in != 8'h0);
  wire sip_ok;
  wire dip_ok;

  always @* begin
    case (proto_mode_q)
      `ACM_PROTO_ANY: proto_ok = 1'b1;
      `ACM_PROTO_SPECIFIC: proto_ok = (hdr_proto_in == proto_q);
      `ACM_PROTO_ICMP: proto_ok = (hdr_proto_in == `ACM_IPPROTO_ICMP);
      `ACM_PROTO_UDP: proto_ok = (hdr_proto_in == `ACM_IPPROTO_UDP);
      `ACM_PROTO_TCP: proto_ok = (hdr_proto_in == `ACM_IPPROTO_TCP);
      default: proto_ok = 1'b0;
    endcase
  end

  always @* begin
    case (ttl_mode_q)
      `ACM_TRI_ANY: ttl_ok = 1'b1;
      `ACM_TRI_NO: ttl_ok = !ttl_nz;
      `ACM_TRI_YES: ttl_ok = ttl_nz;
      default: ttl_ok = 1'b0;
    endcase
    case (frag_mode_q)
      `ACM_TRI_ANY: frag_ok = 1'b1;
      `ACM_TRI_NO: frag_ok = !is_frag;
      `ACM_TRI_YES: frag_ok = is_frag;
      default: frag_ok = 1'b0;
    endcase
    case (opt_mode_q)
      `ACM_TRI_ANY: opt_ok = 1'b1;
      `ACM_TRI_NO: opt_ok = !hdr_options_in;
      `ACM_TRI_YES: opt_ok = hdr_options_in;
      default: opt_ok = 1'b0;
    endcase
  end

  acm_ip_qual u_sip (
    .mode_in(sip_mode_q),
    .stored_addr_in(sip_q),
    .stored_mask_in(sip_mask_q),
    .frame_addr_in(hdr_src_ip_in),
    .ok_out(sip_ok)
  );

  // Same comparator reused on the destination field
  acm_ip_qual u_dip (
    .mode_in(dip_mode_q),
    .stored_addr_in(dip_q),
    .stored_mask_in(dip_mask_q),
    .frame_addr_in(hdr_dst_ip_in),
    .ok_out(dip_ok)
  );

  wire ip_ok = (kind_q != `ACM_KIND_IPV4) ||
    (proto_ok && ttl_ok && frag_ok && opt_ok && sip_ok && dip_ok);

  // ==========================================
  // Verdict
  wire hit = kind_ok && sa_ok && da_ok && vlan_ok && prio_ok && ip_ok;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_valid_out <= 1'b0;
      match_out <= 1'b0;
      drop_out <= 1'b0;
      pass_out <= 1'b0;
      proto_class_out <= `ACM_PROTO_ANY;
    end else begin
      result_valid_out <= hdr_valid_in;
      match_out <= hdr_valid_in && hit;
      drop_out <= hdr_valid_in && hit && (act_q == `ACM_ACT_DENY);
      pass_out <= hdr_valid_in && hit && (act_q == `ACM_ACT_PERMIT);
      // Named protocols hand their class on for the sub-qualifier stage
      if (hdr_valid_in && hit && (kind_q == `ACM_KIND_IPV4) &&
          (proto_mode_q >= `ACM_PROTO_ICMP)) begin
        proto_class_out <= proto_mode_q;
      end else begin
        proto_class_out <= `ACM_PROTO_ANY;
      end
    end
  end
endmodule

// ==== tb/acm_hdr_src.sv ====
// Ingress parser stand-in: hands the matcher one header word per send request.
// Assumes the bench raises send_in for one cycle per frame.
`timescale 1ns/1ps
module acm_hdr_src (
  input wire clk_in,
  input wire send_in,
  input wire [208:0] word_in,
  output logic valid_out,
  output logic [208:0] word_out
);
  initial {valid_out, word_out} = '0;
  // Outside the valid cycle the fields flip, so a stale header never looks usable
  always @(posedge clk_in) begin
    valid_out <= send_in;
    word_out <= send_in ? word_in : ~word_out;
  end
endmodule

// ==== tb/acm_frame_matcher_properties.sv ====
// Checker for result timing and qualifier outcomes of the frame matcher.
// Assumes settings stay put from the edge before each header.
`timescale 1ns/1ps
module acm_fm_props (
  input wire clk_in,
  input wire nrst_in,
  input wire [1:0] entry_kind_in,
  input wire entry_action_in,
  input wire vlan_mode_in,
  input wire [11:0] vlan_id_in,
  input wire [1:0] ttl_mode_in,
  input wire hdr_valid_in,
  input wire [1:0] hdr_kind_in,
  input wire hdr_tagged_in,
  input wire [11:0] hdr_vid_in,
  input wire [7:0] hdr_ttl_in,
  input wire result_valid_out,
  input wire match_out,
  input wire drop_out,
  input wire pass_out,
  input wire [2:0] proto_class_out
);
  // ==========
  // Properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_answer; hdr_valid_in |=> result_valid_out; endproperty
  a_answer: assert property (p_answer) else $error("header got no result");
  property p_quiet; !hdr_valid_in |=> !(result_valid_out | match_out | drop_out | pass_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("output without header");
  property p_act; result_valid_out |-> drop_out == (match_out && $past(entry_action_in, 2));
  endproperty
  a_act: assert property (p_act) else $error("drop disagrees with action");
  property p_pass; result_valid_out |-> pass_out == (match_out && !$past(entry_action_in, 2));
  endproperty
  a_pass: assert property (p_pass) else $error("pass disagrees with action");
  property p_kind; hdr_valid_in && $past(entry_kind_in) != 2'h0
    && hdr_kind_in != $past(entry_kind_in) |=> !match_out; endproperty
  a_kind: assert property (p_kind) else $error("frame kind mismatch matched");
  property p_vlan; hdr_valid_in && $past(vlan_mode_in)
    && !(hdr_tagged_in && hdr_vid_in == $past(vlan_id_in)) |=> !match_out; endproperty
  a_vlan: assert property (p_vlan) else $error("vlan mismatch matched");
  property p_ttl; hdr_valid_in && $past(entry_kind_in) == 2'h3 && $past(ttl_mode_in) == 2'h1
    && hdr_ttl_in != 8'h00 |=> !match_out; endproperty
  a_ttl: assert property (p_ttl) else $error("nonzero ttl matched");
  property p_cls; result_valid_out && proto_class_out != 3'h0 |-> match_out; endproperty
  a_cls: assert property (p_cls) else $error("class without match");
  property p_one; result_valid_out |=> !result_valid_out || $past(hdr_valid_in); endproperty
  a_one: assert property (p_one) else $error("result stretched");
endmodule

bind acm_frame_matcher acm_fm_props u_fm_props (.*);

// ==== tb/acm_frame_matcher_tb.sv ====
// Bench for the frame matcher: random entries and headers checked against a model.
// Assumes the parser stand-in delays each header by one clock.
`timescale 1ns/1ps
module acm_frame_matcher_tb;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic send = 1'b0;
  logic [1:0] entry_kind_in, ttl_mode_in, frag_mode_in, opt_mode_in, hk;
  logic [1:0] source_ipv4_mode_in, destination_ipv4_mode_in;
  logic entry_action_in, source_hw_address_mode_in, vlan_mode_in, prio_mode_in, tag, mf, opt;
  logic [2:0] destination_hw_address_mode_in, proto_mode_in, prio_in, hpr;
  logic [7:0] proto_in, hp, ttl;
  logic [11:0] vlan_id_in, hvid;
  logic [12:0] fo;
  logic [47:0] source_hw_address_in, destination_hw_address_in, hsa, hda;
  logic [31:0] source_ipv4_address_in, source_ipv4_mask_in, hsi, hdi, seed = 32'hDC1AAA07;
  logic [31:0] destination_ipv4_address_in, destination_ipv4_mask_in;
  logic [31:0] w [8];
  logic [208:0] hw, hq;
  wire hdr_valid_in, hdr_tagged_in, hdr_more_fragments_flag_in, hdr_options_in;
  wire [1:0] hdr_kind_in;
  wire [47:0] hdr_src_hw_in, hdr_dst_hw_in;
  wire [11:0] hdr_vid_in;
  wire [2:0] hdr_prio_in, proto_class_out;
  wire [7:0] hdr_proto_in, hdr_ttl_in;
  wire [12:0] hdr_fragment_position_field_in;
  wire [31:0] hdr_src_ip_in, hdr_dst_ip_in;
  wire result_valid_out, match_out, drop_out, pass_out;
  logic [5:0] q [$];
  int bad_count = 0, tests_run = 0, cyc = 0;

  assign {hdr_kind_in, hdr_src_hw_in, hdr_dst_hw_in, hdr_tagged_in, hdr_vid_in, hdr_prio_in,
    hdr_proto_in, hdr_ttl_in, hdr_more_fragments_flag_in, hdr_fragment_position_field_in,
    hdr_options_in, hdr_src_ip_in, hdr_dst_ip_in} = hq;
  acm_hdr_src src (.clk_in(clk_in), .send_in(send), .word_in(hw), .valid_out(hdr_valid_in),
    .word_out(hq));
  acm_frame_matcher dut (.*);
  always #4 clk_in = ~clk_in;

  // ==========
  // Model
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  function automatic logic ipq(input logic [1:0] md, input logic [31:0] a, k, h);
    return md == 0 || md == 1 && h == a || md == 2 && (h & k) == (a & k);
  endfunction
  function automatic logic [5:0] model();
    logic m;
    logic [1:0] ek;
    logic [2:0] pm, dm;
    ek = entry_kind_in;
    pm = proto_mode_in;
    dm = destination_hw_address_mode_in;
    m = (ek == 0 || hk == ek)
      && !(ek[1] ^ ek[0] && source_hw_address_mode_in && hsa != source_hw_address_in)
      && (dm == 0 || dm == 1 && hda[40] || dm == 2 && &hda || dm == 3 && !hda[40]
      || dm == 4 && hda == destination_hw_address_in)
      && !(vlan_mode_in && !(tag && hvid == vlan_id_in))
      && !(prio_mode_in && !(tag && hpr == prio_in));
    if (ek == 3)
      m = m && (pm == 0 || pm == 1 && hp == proto_in || pm == 2 && hp == 8'h01
        || pm == 3 && hp == 8'h11 || pm == 4 && hp == 8'h06)
        && (ttl_mode_in == 0 || ttl_mode_in == 1 && ttl == 0 || ttl_mode_in == 2 && ttl != 0)
        && (frag_mode_in == 0 || frag_mode_in - 1 == (mf || fo != 0))
        && (opt_mode_in == 0 || opt_mode_in - 1 == opt)
        && ipq(source_ipv4_mode_in, source_ipv4_address_in, source_ipv4_mask_in, hsi)
        && ipq(destination_ipv4_mode_in, destination_ipv4_address_in, destination_ipv4_mask_in, hdi);
    return {m, m & entry_action_in, m & !entry_action_in,
      (m && ek == 3 && pm >= 2 && pm <= 4) ? pm : 3'h0};
  endfunction

  // ==========
  // Stimulus and checks
  task automatic gen();
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      w[i] = seed;
    end
    {destination_ipv4_mode_in, source_ipv4_mode_in, opt_mode_in, frag_mode_in, ttl_mode_in,
      proto_mode_in, prio_mode_in, vlan_mode_in, destination_hw_address_mode_in,
      source_hw_address_mode_in, entry_action_in, entry_kind_in} <= w[0][21:0];
    {prio_in, proto_in, vlan_id_in} <= {w[0][24:22], w[1][7:0], w[1][19:9], 1'b1};
    {source_hw_address_in, destination_hw_address_in} <= {w[2][15:0], w[3], w[3][15:0], w[2]};
    {source_ipv4_address_in, destination_ipv4_address_in} <= {w[5], w[6]};
    source_ipv4_mask_in <= ~(32'hFFFFFFFF >> w[4][8:4]);
    destination_ipv4_mask_in <= ~(32'hFFFFFFFF >> w[4][20:16]);
    hk = w[1][20] ? w[0][1:0] : w[1][22:21];
    hsa = {w[4][0] ? w[2][15:0] : w[7][15:0], w[3]};
    hda = w[4][1] ? {w[3][15:0], w[2]} : w[4][2] ? 48'hFFFFFFFFFFFF : {w[7][15:0], w[2]};
    tag = w[1][23] | w[4][3];
    hvid = w[1][24] ? {w[1][19:9], 1'b1} : w[7][11:0];
    hpr = w[1][25] ? w[0][24:22] : w[1][28:26];
    hp = w[1][29] ? w[1][7:0] : w[1][30] ? 8'h01 : w[1][31] ? 8'h11 : 8'h06;
    {ttl, mf, opt} = {w[4][9] ? 8'h00 : w[7][7:0], &w[4][11:10], w[4][14]};
    fo = &w[4][13:12] ? w[7][20:8] : 13'h0000;
    hsi = w[4][15] ? w[5] ^ ({32{w[4][22]}} & (w[7] >> w[4][8:4])) : w[7];
    hdi = w[4][21] ? w[6] ^ ({32{w[4][23]}} & (w[3] >> w[4][20:16])) : w[3];
    hw <= {hk, hsa, hda, tag, hvid, hpr, hp, ttl, mf, fo, opt, hsi, hdi};
  endtask
  task automatic check_result(input logic [5:0] e, input logic [5:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(negedge clk_in) begin
    if (send === 1'b1) q.push_back(model());
    if (result_valid_out === 1'b1)
      check_result(q.pop_front(), {match_out, drop_out, pass_out, proto_class_out});
  end
  // Hang guard: the run needs about 3011 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    gen();
    repeat (5) @(posedge clk_in);
    check_result(6'h00, {match_out, drop_out, pass_out, proto_class_out});
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    $display("test reset done");
    // Back-to-back frames, with fresh entry settings on every cycle
    for (int n = 0; n < 3000; n++) begin
      gen();
      send <= 1'b1;
      @(posedge clk_in);
    end
    send <= 1'b0;
    repeat (4) @(posedge clk_in);
    check_result(6'h00, {5'h00, q.size() != 0});
    $display("test random entries done");
    final_report();
  end
endmodule
